// [logic/adc_serial_command_engine.sv]
// Command interpreter of the converter: decodes serial commands, serves results and registers.
// Assumes conversion and calibration engines on mclk; serial pins from the host on their own clock.

`timescale 1ns/100ps
`default_nettype none

module adc_serial_command_engine
    import adc_cmd_pkg::*;
#(
    parameter logic [15:0] HOLD_CYCLES = 16'(RESET_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Conversion control
    input wire logic start,
    output logic data_ready_n,
    output logic sleep,
    output logic in_reset,
    output logic filter_clear,
    input wire conv_result_t conv,
    // Calibration
    output logic cal_start,
    output cal_kind_t cal_kind,
    input wire cal_result_t cal,
    // Configuration registers
    output logic [REG_COUNT-1:0][7:0] reg_file
);

    typedef struct packed {
        cmd_state_t st;
        logic [3:0] addr;
        logic [3:0] left;
        logic [REG_COUNT-1:0][7:0] regs;
        logic [23:0] latest;
        logic [23:0] res_buf;
        logic [1:0] res_left;
        logic [7:0] tx_hold;
        logic cont_mode;
        logic enter_cont;
        logic exit_cont;
        logic data_ready_n_n;
        logic sleep;
        logic filter_clear;
        logic busy;
        logic [15:0] hold_cnt;
        cal_kind_t cal_kind;
        logic cal_start;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic go_s1;
        logic go_s2;
    } engine_t;

    localparam engine_t ENGINE_RESET = '{
        st: ST_CMD,
        addr: 4'h0,
        left: 4'h0,
        regs: REG_RESET_VALUE,
        latest: 24'h0,
        res_buf: 24'h0,
        res_left: 2'h0,
        tx_hold: NOP_BYTE,
        cont_mode: 1'b1,
        enter_cont: 1'b0,
        exit_cont: 1'b0,
        data_ready_n_n: 1'b1,
        sleep: 1'b0,
        filter_clear: 1'b1,
        busy: 1'b1,
        hold_cnt: HOLD_CYCLES,
        cal_kind: CAL_NONE,
        cal_start: 1'b0,
        rx_s1: 1'b0,
        rx_s2: 1'b0,
        rx_prev: 1'b0,
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_prev: 1'b1,
        go_s1: 1'b0,
        go_s2: 1'b0
    };

    engine_t s_reg, s_next;
    link_byte_t link_rx;
    logic rx_new;
    logic cs_release;
    logic [7:0] rx_byte;
    logic [7:0] rx_cmd;

    // ****************************************
    // Serial byte link
    // ****************************************
    spi_byte_link u_link (
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .dout_oe(dout_oe),
        .tx_byte(s_reg.tx_hold),
        .rx(link_rx)
    );

    assign rx_new = s_reg.rx_s2 != s_reg.rx_prev;
    assign cs_release = s_reg.cs_s2 && !s_reg.cs_prev;
    assign rx_byte = link_rx.data;
    assign rx_cmd = link_rx.data & CMD_LSB_MASK;

    // ****************************************
    // Command engine
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.cal_start = 1'b0;
        s_next.rx_s1 = link_rx.tgl;
        s_next.rx_s2 = s_reg.rx_s1;
        s_next.rx_prev = s_reg.rx_s2;
        s_next.cs_s1 = cs_n;
        s_next.cs_s2 = s_reg.cs_s1;
        s_next.cs_prev = s_reg.cs_s2;
        s_next.go_s1 = start;
        s_next.go_s2 = s_reg.go_s1;

        // Reset hold: registers and filter stay in reset until the count expires
        if (s_reg.busy) begin
            s_next.regs = REG_RESET_VALUE;
            if (s_reg.hold_cnt <= 16'h1) begin
                s_next.busy = 1'b0;
                s_next.filter_clear = 1'b0;
                s_next.hold_cnt = 16'h0;
            end else begin
                s_next.hold_cnt = s_reg.hold_cnt - 16'h1;
            end
        end else begin
            s_next.filter_clear = 1'b0;
        end

        if (s_reg.go_s2) begin
            s_next.sleep = 1'b0;
        end

        if (cs_release) begin
            s_next.st = ST_CMD;
        end else if (rx_new && !s_reg.busy) begin
            s_next.data_ready_n_n = 1'b1;
            if (s_reg.res_left == 2'h2) begin
                s_next.tx_hold = s_reg.res_buf[15:8];
                s_next.res_left = 2'h1;
            end else if (s_reg.res_left == 2'h1) begin
                s_next.tx_hold = s_reg.res_buf[7:0];
                s_next.res_left = 2'h0;
            end else begin
                s_next.tx_hold = NOP_BYTE;
            end
            unique case (s_reg.st)
                ST_CMD: begin
                    if (rx_cmd == CMD_SYNC) begin
                        s_next.st = ST_SYNC2;
                    end else if (rx_cmd == CMD_SOFT_RESET) begin
                        // Serial framing is left alone; only the device state is reset
                        s_next.regs = REG_RESET_VALUE;
                        s_next.busy = 1'b1;
                        s_next.hold_cnt = HOLD_CYCLES;
                        s_next.filter_clear = 1'b1;
                        s_next.cont_mode = 1'b1;
                        s_next.enter_cont = 1'b0;
                        s_next.exit_cont = 1'b0;
                        s_next.res_left = 2'h0;
                        s_next.tx_hold = NOP_BYTE;
                        s_next.cal_kind = CAL_NONE;
                    end else if (rx_cmd == CMD_READ_ONCE) begin
                        s_next.res_buf = s_reg.latest;
                        s_next.tx_hold = s_reg.latest[23:16];
                        s_next.res_left = RESULT_BYTES_AFTER_FIRST;
                    end else if (rx_cmd == CMD_CONT_READ) begin
                        s_next.enter_cont = 1'b1;
                        s_next.exit_cont = 1'b0;
                    end else if (rx_cmd == CMD_STOP_CONT) begin
                        s_next.exit_cont = 1'b1;
                        s_next.enter_cont = 1'b0;
                    end else if (rx_byte[7:4] == OP_REG_READ) begin
                        s_next.addr = rx_byte[3:0];
                        s_next.st = ST_REGISTER_READ_CMD_N;
                    end else if (rx_byte[7:4] == OP_REG_WRITE) begin
                        s_next.addr = rx_byte[3:0];
                        s_next.st = ST_REGISTER_WRITE_CMD_N;
                    end else if (rx_byte == CMD_SYS_OFFSET_CAL) begin
                        s_next.cal_start = 1'b1;
                        s_next.cal_kind = CAL_SYS_OFFSET;
                    end else if (rx_byte == CMD_SYS_GAIN_CAL) begin
                        s_next.cal_start = 1'b1;
                        s_next.cal_kind = CAL_SYS_GAIN;
                    end else if (rx_byte == CMD_SELF_OFFSET_CAL) begin
                        s_next.cal_start = 1'b1;
                        s_next.cal_kind = CAL_SELF_OFFSET;
                    end
                end
                ST_SYNC2: begin
                    if (rx_cmd == CMD_SYNC) begin
                        s_next.filter_clear = 1'b1;
                    end
                    s_next.st = ST_CMD;
                end
                ST_REGISTER_READ_CMD_N: begin
                    s_next.left = rx_byte[3:0];
                    s_next.tx_hold = s_reg.regs[s_reg.addr];
                    s_next.st = ST_REGISTER_READ_CMD_OUT;
                end
                ST_REGISTER_READ_CMD_OUT: begin
                    // Incoming bytes are not decoded while registers stream out
                    if (s_reg.left == 4'h0) begin
                        s_next.st = ST_CMD;
                    end else begin
                        s_next.addr = s_reg.addr + 4'h1;
                        s_next.left = s_reg.left - 4'h1;
                        s_next.tx_hold = s_reg.regs[s_reg.addr + 4'h1];
                    end
                end
                ST_REGISTER_WRITE_CMD_N: begin
                    s_next.left = rx_byte[3:0];
                    s_next.st = ST_REGISTER_WRITE_CMD_DATA;
                end
                ST_REGISTER_WRITE_CMD_DATA: begin
                    s_next.regs[s_reg.addr] = rx_byte;
                    s_next.addr = s_reg.addr + 4'h1;
                    if (s_reg.left == 4'h0) begin
                        s_next.st = ST_CMD;
                    end else begin
                        s_next.left = s_reg.left - 4'h1;
                    end
                end
                default: begin
                    s_next.st = ST_CMD;
                end
            endcase
        end

        // New result: data-ready falls, mode changes take effect at this event
        if (conv.done && !s_reg.busy) begin
            s_next.latest = conv.data;
            s_next.data_ready_n_n = 1'b0;
            if (!s_reg.go_s2) begin
                s_next.sleep = 1'b1;
            end
            if (s_reg.cont_mode || s_reg.enter_cont) begin
                s_next.res_buf = conv.data;
                s_next.tx_hold = conv.data[23:16];
                s_next.res_left = RESULT_BYTES_AFTER_FIRST;
            end
            // A mode command arriving with this result stays pending for the next one
            if (s_reg.enter_cont) begin
                s_next.cont_mode = 1'b1;
                s_next.enter_cont = 1'b0;
            end else if (s_reg.exit_cont) begin
                s_next.cont_mode = 1'b0;
                s_next.exit_cont = 1'b0;
            end
        end

        // Calibration result lands in the matching calibration register
        if (cal.done && !s_reg.busy) begin
            for (int i = 0; i < 3; i++) begin
                if (s_reg.cal_kind == CAL_SYS_GAIN) begin
                    s_next.regs[FULL_SCALE_CAL_ADDR + 4'(i)] = cal.value[8*i +: 8];
                end else if (s_reg.cal_kind != CAL_NONE) begin
                    s_next.regs[OFFSET_CAL_ADDR + 4'(i)] = cal.value[8*i +: 8];
                end
            end
            // A calibration command in this very cycle keeps its new kind
            if (!s_next.cal_start) begin
                s_next.cal_kind = CAL_NONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= ENGINE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_ready_n = s_reg.data_ready_n_n;
    assign sleep = s_reg.sleep;
    assign in_reset = s_reg.busy;
    assign filter_clear = s_reg.filter_clear;
    assign cal_start = s_reg.cal_start;
    assign cal_kind = s_reg.cal_kind;
    assign reg_file = s_reg.regs;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_sync_clears_filter: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_SYNC2 && rx_cmd == CMD_SYNC)
        |=> s_reg.filter_clear ##1 !s_reg.filter_clear)
        else $error("sync did not pulse filter clear");

    a_reset_restores_regs: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_CMD && rx_cmd == CMD_SOFT_RESET)
        |=> s_reg.busy && s_reg.filter_clear && s_reg.regs == REG_RESET_VALUE && s_reg.cont_mode)
        else $error("soft reset did not restore state");

    a_hold_counts_down: assert property (
        (s_reg.busy && s_reg.hold_cnt > 16'h1 && !rx_new)
        |=> s_reg.busy && s_reg.hold_cnt == $past(s_reg.hold_cnt) - 16'h1)
        else $error("reset hold count broken");

    a_cs_idles_decoder: assert property (
        cs_release |=> s_reg.st == ST_CMD)
        else $error("chip select release did not idle decoder");

    a_cont_loads_result: assert property (
        (conv.done && !s_reg.busy && s_reg.cont_mode)
        |=> s_reg.tx_hold == $past(conv.data[23:16]) && s_reg.res_left == 2'h2 && !s_reg.data_ready_n_n)
        else $error("continuous mode did not load result");

    a_stop_waits_ready: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_CMD && rx_cmd == CMD_STOP_CONT
         && s_reg.cont_mode && !conv.done)
        |=> s_reg.cont_mode && s_reg.exit_cont)
        else $error("stop took effect early");

    a_read_once_loads: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_CMD && rx_cmd == CMD_READ_ONCE && !conv.done)
        |=> s_reg.tx_hold == $past(s_reg.latest[23:16]) && s_reg.res_left == 2'h2)
        else $error("single read did not load latest result");

    a_register_read_cmd_ignores_cmds: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_REGISTER_READ_CMD_OUT)
        |=> !s_reg.cal_start && $stable(s_reg.enter_cont) && $stable(s_reg.busy))
        else $error("command decoded during register readout");

    a_register_write_cmd_stores_byte: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_REGISTER_WRITE_CMD_DATA && !cal.done)
        |=> s_reg.regs[$past(s_reg.addr)] == $past(rx_byte))
        else $error("register write lost");

    a_offset_cal_start: assert property (
        (rx_new && !cs_release && !s_reg.busy && s_reg.st == ST_CMD && rx_byte == CMD_SYS_OFFSET_CAL)
        |=> s_reg.cal_start && s_reg.cal_kind == CAL_SYS_OFFSET ##1 !s_reg.cal_start)
        else $error("offset calibration not started");

    a_sleep_on_ready: assert property (
        (conv.done && !s_reg.busy && !s_reg.go_s2) |=> s_reg.sleep && !s_reg.data_ready_n_n)
        else $error("sleep not entered at data ready");

endmodule

`default_nettype wire

// [logic/adc_cmd_pkg.sv]
// Constants, types and carriers shared by the serial command engine and its byte link.
// Assumes one system clock (mclk, 50 MHz) and a serial link clock driven by the host.
//
// Behaviour
// - Filter-synchronise command clears the decimation filter and restarts conversion.
// - Soft reset restores every configuration register and clears the filter.
// - Soft reset leaves serial framing alone; misframed bytes reset nothing.
// - Chip select deassertion returns serial framing and command decoding to idle.
// - Soft reset holds registers and filter in reset 0.6 ms; host waits.
// - Continuous-read mode loads each new result for 24-clock readout.
// - Continuous-read command sent after data-ready falls; takes effect next fall.
// - Stop-continuous-read ends automatic result loading into the output register.
// - Stop-continuous-read takes effect only after the next data-ready event.
// - Single-read copies latest result for 24-clock readout, in either mode.
// - Next single-read may arrive during the final result byte, full duplex.
// - Register read 0010 rrrr, 0000 nnnn returns nnnn+1 registers, wrapping.
// - Bytes received during register readout are ignored; host sends no-ops.
// - Register write 0100 rrrr, 0000 nnnn, then nnnn+1 data bytes.
// - System offset calibration updates the offset calibration register when done.
// - System gain calibration updates the full-scale calibration register when done.
// - Self offset calibration shorts inputs internally, then updates offset register.
// - After power-up or reset the device is in continuous-read mode.
// - A register write may be shifted in during a result readout.
// - Start low: sleep after data-ready falls, result still readable.
// - Filter-synchronise is 0000 010x, sent twice in succession.
// - Soft reset is the single byte 0000 011x, low bit ignored.
// - Single, continuous and stop reads are 0001 001x, 010x, 011x.

package adc_cmd_pkg;

    // ****************************************
    // Command encodings
    // ****************************************
    localparam logic [7:0] CMD_LSB_MASK = 8'hfe;
    localparam logic [7:0] CMD_SYNC = 8'h04;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
    localparam logic [7:0] CMD_READ_ONCE = 8'h12;
    localparam logic [7:0] CMD_CONT_READ = 8'h14;
    localparam logic [7:0] CMD_STOP_CONT = 8'h16;
    localparam logic [3:0] OP_REG_READ = 4'h2;
    localparam logic [3:0] OP_REG_WRITE = 4'h4;
    localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'h60;
    localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'h61;
    localparam logic [7:0] CMD_SELF_OFFSET_CAL = 8'h62;
    localparam logic [7:0] NOP_BYTE = 8'hff;

    // ****************************************
    // Register file
    // ****************************************
    localparam int REG_COUNT = 16;
    localparam logic [3:0] OFFSET_CAL_ADDR = 4'h4;
    localparam logic [3:0] FULL_SCALE_CAL_ADDR = 4'h7;
    localparam logic [127:0] REG_RESET_VALUE = 128'h0;
    localparam logic [1:0] RESULT_BYTES_AFTER_FIRST = 2'h2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int MCLK_PERIOD_NS = 20;
    localparam int RESET_HOLD_NS = 600000;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {CAL_NONE, CAL_SYS_OFFSET, CAL_SYS_GAIN, CAL_SELF_OFFSET} cal_kind_t;

    typedef enum logic [2:0] {ST_CMD, ST_SYNC2, ST_REGISTER_READ_CMD_N, ST_REGISTER_READ_CMD_OUT, ST_REGISTER_WRITE_CMD_N, ST_REGISTER_WRITE_CMD_DATA} cmd_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic tgl;
    } link_byte_t;

    typedef struct packed {
        logic done;
        logic [23:0] data;
    } conv_result_t;

    typedef struct packed {
        logic done;
        logic [23:0] value;
    } cal_result_t;

endpackage

// [logic/spi_byte_link.sv]
// Serial byte link on the host's serial clock: shifts bytes in and out, MSB first.
// Assumes the host leaves at least 200 ns between bytes so the engine can refresh tx_byte.

`timescale 1ns/100ps
`default_nettype none

module spi_byte_link
    import adc_cmd_pkg::*;
(
    // Reset
    input wire logic rst_n,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Engine side
    input wire logic [7:0] tx_byte,
    output link_byte_t rx
);

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] rx_sh;
        logic [7:0] tx_sh;
    } frame_t;

    frame_t f_reg, f_next;
    link_byte_t h_reg, h_next;
    logic frame_rst_n;

    // ****************************************
    // Framing, cleared whenever chip select is high
    // ****************************************
    assign frame_rst_n = rst_n & ~cs_n;

    always_comb begin
        f_next = f_reg;
        h_next = h_reg;
        f_next.cnt = f_reg.cnt + 3'h1;
        f_next.rx_sh = {f_reg.rx_sh[5:0], din};
        if (f_reg.cnt == 3'h0) begin
            f_next.tx_sh = {tx_byte[6:0], 1'b1};
        end else begin
            f_next.tx_sh = {f_reg.tx_sh[6:0], 1'b1};
        end
        if (f_reg.cnt == 3'h7) begin
            h_next.data = {f_reg.rx_sh, din};
            h_next.tgl = ~h_reg.tgl;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    // Handoff toggle survives frame ends so the engine never sees a false byte
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    assign dout = (f_reg.cnt == 3'h0) ? tx_byte[7] : f_reg.tx_sh[7];
    assign dout_oe = ~cs_n;
    assign rx = h_reg;

endmodule

`default_nettype wire

// [bench/spi_host_model.sv]
// Host end of the serial link: a behavioural SPI master that frames whole bytes.
// Assumes the engine shows bit 7 before the first sclk rising and shifts on each rising edge;
// the host samples dout just before every rising edge.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    // ********
    // Frame and byte tasks
    // ********
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end
    // Released din shows the inverse of its last value
    task automatic select(input logic on);
        #7 cs_n = ~on;
        din = ~din;
        #40;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            #15 rx[i] = dout;
            sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        #200 din = ~din;
    endtask
endmodule
`default_nettype wire

// [bench/test_adc_serial_command_engine.sv]
// Self-checking bench for the serial command engine with an integer register model.
// Assumes the host model in spi_host_model.sv and the design package.
`timescale 1ns/100ps
`default_nettype none
module test_adc_serial_command_engine;
    import adc_cmd_pkg::*;
    logic mclk, rst_n, start, sclk, cs_n, din, dout, dout_oe;
    logic data_ready_n, sleep, in_reset, filter_clear, cal_start;
    conv_result_t conv;
    cal_result_t cal;
    cal_kind_t cal_kind, kind_seen;
    logic [REG_COUNT-1:0][7:0] reg_file;
    logic [7:0] rx, q[$], b[3];
    logic [23:0] d;
    int miscompares = 0, tests_run = 0, n_cal = 0, n_clr = 0, regs[16];

    adc_serial_command_engine #(.HOLD_CYCLES(16'h0014)) adc_serial_command_engine_inst (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .start(start), .data_ready_n(data_ready_n), .sleep(sleep),
        .in_reset(in_reset), .filter_clear(filter_clear), .conv(conv), .cal_start(cal_start),
        .cal_kind(cal_kind), .cal(cal), .reg_file(reg_file));
    spi_host_model spi_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    // ********
    // Clock, monitors and tasks
    // ********
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (cal_start) begin
            n_cal++;
            kind_seen = cal_kind;
        end
        if (filter_clear && !in_reset) n_clr++;
    end
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 16; i++) chk(24'(reg_file[i]), 24'(regs[i]));
    endtask
    task automatic send(input logic [7:0] s[$]);
        q = {};
        spi_host_model_inst.select(1'b1);
        foreach (s[i]) begin
            spi_host_model_inst.xfer(s[i], rx);
            q.push_back(rx);
        end
        spi_host_model_inst.select(1'b0);
    endtask
    task automatic pulse(input logic k, input logic [23:0] v);
        repeat (4) @(posedge mclk);
        #2;
        if (k) cal = {1'b1, v};
        else conv = {1'b1, v};
        @(posedge mclk);
        #2;
        cal.done = 1'b0;
        conv.done = 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic results();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 100 && in_reset !== 1'b0; k++) @(posedge mclk);
        if (k == 100) begin
            miscompares++;
            $display("unexpected at %0t: hold never ended", $time);
            results();
        end
        #2;
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        void'($urandom(11));
        rst_n = 1'b0;
        start = 1'b1;
        conv = '0;
        cal = '0;
        foreach (regs[i]) regs[i] = 0;
        repeat (5) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        chk(in_reset, 1'b1);
        chk(dout_oe, 1'b0);
        wait_idle();
        chk_regs();
        d = 24'($urandom);
        b = '{8'($urandom), 8'($urandom), 8'($urandom)};
        pulse(1'b0, d);
        chk(data_ready_n, 1'b0);
        send('{8'h4e, 8'h00, b[0]});
        chk({q[0], q[1], q[2]}, d);
        send('{8'h40, 8'h01, b[1], b[2]});
        regs[14] = b[0];
        regs[0] = b[1];
        regs[1] = b[2];
        chk_regs();
        send('{8'h2e, 8'h03, NOP_BYTE, CMD_SOFT_RESET, NOP_BYTE, NOP_BYTE});
        chk({q[2], q[3], q[4]}, {b[0], 8'h00, b[1]});
        chk(q[5], b[2]);
        chk(in_reset, 1'b0);
        for (int c = 0; c < 3; c++) begin
            d = 24'($urandom);
            send('{8'(CMD_SYS_OFFSET_CAL + c)});
            chk(24'(n_cal), 24'(c + 1));
            chk(kind_seen, 24'(c + 1));
            pulse(1'b1, d);
            for (int i = 0; i < 3; i++) regs[(c == 1 ? 7 : 4) + i] = d[8 * i +: 8];
            chk_regs();
        end
        send('{CMD_SYNC, 8'h05});
        send('{CMD_SYNC, NOP_BYTE});
        chk(24'(n_clr), 24'h1);
        send('{CMD_STOP_CONT});
        d = 24'($urandom);
        pulse(1'b0, d);
        send('{NOP_BYTE, NOP_BYTE, NOP_BYTE});
        chk({q[0], q[1], q[2]}, d);
        d = 24'($urandom);
        pulse(1'b0, d);
        send('{8'h20, 8'h00, NOP_BYTE});
        chk(q[2], regs[0][7:0]);
        chk(q[0], NOP_BYTE);
        send('{CMD_READ_ONCE, NOP_BYTE, NOP_BYTE, 8'h13, NOP_BYTE, NOP_BYTE, NOP_BYTE});
        chk({q[1], q[2], q[3]}, d);
        chk({q[4], q[5], q[6]}, d);
        send('{8'h07});
        chk(in_reset, 1'b1);
        wait_idle();
        foreach (regs[i]) regs[i] = 0;
        chk_regs();
        start = 1'b0;
        d = 24'($urandom);
        pulse(1'b0, d);
        chk(sleep, 1'b1);
        send('{NOP_BYTE, NOP_BYTE, NOP_BYTE});
        chk({q[0], q[1], q[2]}, d);
        results();
    end
endmodule
`default_nettype wire
